// [hdl/sdc_map.svh]
`ifndef SDC_MAP_SVH
`define SDC_MAP_SVH

// register byte offsets
`define SDC_REG_CTRL        8'h00
`define SDC_REG_PRESET      8'h04
`define SDC_REG_CMD         8'h08
`define SDC_REG_STATUS      8'h0C
`define SDC_REG_WRAPS       8'h10
`define SDC_REG_MATCH       8'h14
`define SDC_REG_INFO        8'h18

// control register fields and reset value
`define SDC_CTRL_CEP_BIT    0
`define SDC_CTRL_CET_BIT    1
`define SDC_CTRL_RESET      32'h0000_0003
`define SDC_CTRL_RESET_CEP  1'b1
`define SDC_CTRL_RESET_CET  1'b1

// command register fields (write-only, self clearing)
`define SDC_CMD_LOAD_BIT    0
`define SDC_CMD_CLEAR_BIT   1
`define SDC_CMD_MATCH_BIT   2
`define SDC_CMD_WRAPS_BIT   3

// status register fields above the packed count digits
`define SDC_STAT_TF_BIT     31
`define SDC_STAT_MATCH_BIT  30

// decade sequence
`define SDC_DIGIT_FIRST     4'h0
`define SDC_DIGIT_LAST      4'h9
`define SDC_DIGIT_STEP      4'h1

// read data stands this many cycles after the read strobe
`define SDC_READ_LATENCY    1

`endif

// [hdl/sdc_pkg.sv]
`default_nettype none
package sdc_pkg;

  // controls seen by one decade stage at a clock edge
  typedef struct packed {
    logic sync_clear;
    logic load_n;
    logic count_enable_parallel;
    logic count_enable_trickle;
  } sdc_stage_ctrl_type;

  // one register bus cycle as the master presents it
  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } sdc_bus_req_type;

  typedef enum logic [2:0] {
    SDC_SEL_CTRL   = 3'b000,
    SDC_SEL_PRESET = 3'b001,
    SDC_SEL_CMD    = 3'b010,
    SDC_SEL_STATUS = 3'b011,
    SDC_SEL_WRAPS  = 3'b100,
    SDC_SEL_MATCH  = 3'b101,
    SDC_SEL_INFO   = 3'b110,
    SDC_SEL_NONE   = 3'b111
  } sdc_reg_sel_type;

endpackage : sdc_pkg

`default_nettype wire

// [hdl/sdc_decade_stage.sv]
`timescale 1ns/1ps
`default_nettype none
`include "sdc_map.svh"

module sdc_decade_stage #(
  parameter bit ASYNC_CLEAR = 1'b1
) (
  // clock and reset
  input  wire logic                        clk_sys_in,
  input  wire logic                        rst_in,
  // counter controls
  input  wire logic                        clear_n_in,
  input  wire sdc_pkg::sdc_stage_ctrl_type ctrl_in,
  input  wire logic [3:0]                  preset_in,
  // counter state
  output logic      [3:0]                  count_out,
  output logic                             terminal_flag_out
);

  logic [3:0] count;
  logic [3:0] next_count;

  always_comb begin
    if (ctrl_in.sync_clear) begin
      next_count = `SDC_DIGIT_FIRST;
    end else if (!ctrl_in.load_n) begin
      next_count = preset_in;
    end else if (ctrl_in.count_enable_parallel && ctrl_in.count_enable_trickle) begin
      // an out-of-range preset simply steps on through the 4-bit range
      next_count = (count == `SDC_DIGIT_LAST) ? `SDC_DIGIT_FIRST : count + `SDC_DIGIT_STEP;
    end else begin
      next_count = count;
    end
  end

  generate
    if (ASYNC_CLEAR) begin : g_async_clear
      always_ff @(posedge clk_sys_in or negedge clear_n_in) begin
        if (!clear_n_in) begin
          count <= `SDC_DIGIT_FIRST;
        end else if (rst_in) begin
          count <= `SDC_DIGIT_FIRST;
        end else begin
          count <= next_count;
        end
      end
    end else begin : g_sync_clear
      always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
          count <= `SDC_DIGIT_FIRST;
        end else begin
          count <= next_count;
        end
      end
    end
  endgenerate

  assign count_out         = count;
  // zero count under clear also forces the flag low
  assign terminal_flag_out = ctrl_in.count_enable_trickle && (count == `SDC_DIGIT_LAST);

endmodule : sdc_decade_stage

`default_nettype wire

// [hdl/sdc_counter_top.sv]
// The implementer's own choices: the address map and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
`include "sdc_map.svh"

// Function
// - Four-bit count steps once per edge when loading is off and both enables high; nine wraps to zero.
// - Async variant: low clear zeroes count and terminal flag at once, no edge needed.
// - Load, enables and preset are sampled only on the rising clock edge; clear is sampled there only in the sync variant.
// - Low load at an edge copies the preset inputs, whatever the enables say.
// - Load off and either enable low: the count keeps its previous value.
// - Terminal flag is high only with trickle enable high and count at nine.
module sdc_counter_top #(
  parameter int          NUM_STAGES  = 1,
  parameter bit          ASYNC_CLEAR = 1'b1,
  // arbitrary value, identifies this build to software only
  parameter logic [31:0] INFO_CODE   = 32'h0000_0A01
) (
  // clock and reset
  input  wire logic                      clk_sys_in,
  input  wire logic                      rst_in,
  // counter pins
  input  wire logic                      clear_n_in,
  input  wire logic                      load_n_in,
  input  wire logic                      count_enable_parallel_in,
  input  wire logic                      count_enable_trickle_in,
  input  wire logic [4*NUM_STAGES-1:0]   preset_in,
  output logic      [4*NUM_STAGES-1:0]   count_out,
  output logic                           terminal_flag_out,
  // register port
  input  wire logic [7:0]                reg_addr_in,
  input  wire logic [31:0]               reg_wdata_in,
  input  wire logic                      reg_wr_in,
  input  wire logic                      reg_rd_in,
  output logic      [31:0]               reg_rdata_out
);

  localparam int CW = 4 * NUM_STAGES;

  function automatic sdc_pkg::sdc_reg_sel_type reg_sel(input logic [7:0] addr);
    case (addr)
      `SDC_REG_CTRL:   reg_sel = sdc_pkg::SDC_SEL_CTRL;
      `SDC_REG_PRESET: reg_sel = sdc_pkg::SDC_SEL_PRESET;
      `SDC_REG_CMD:    reg_sel = sdc_pkg::SDC_SEL_CMD;
      `SDC_REG_STATUS: reg_sel = sdc_pkg::SDC_SEL_STATUS;
      `SDC_REG_WRAPS:  reg_sel = sdc_pkg::SDC_SEL_WRAPS;
      `SDC_REG_MATCH:  reg_sel = sdc_pkg::SDC_SEL_MATCH;
      `SDC_REG_INFO:   reg_sel = sdc_pkg::SDC_SEL_INFO;
      default:         reg_sel = sdc_pkg::SDC_SEL_NONE;
    endcase
  endfunction : reg_sel

  sdc_pkg::sdc_bus_req_type bus;
  sdc_pkg::sdc_reg_sel_type wr_sel;
  sdc_pkg::sdc_reg_sel_type rd_sel;

  assign bus.addr  = reg_addr_in;
  assign bus.wdata = reg_wdata_in;
  assign bus.wr    = reg_wr_in;
  assign bus.rd    = reg_rd_in;
  assign wr_sel    = bus.wr ? reg_sel(bus.addr) : sdc_pkg::SDC_SEL_NONE;
  assign rd_sel    = bus.rd ? reg_sel(bus.addr) : sdc_pkg::SDC_SEL_NONE;

  // software state
  logic          sw_cep_gate;
  logic          sw_cet_gate;
  logic [CW-1:0] sw_preset;
  logic [CW-1:0] match_value;
  logic          match_hit;
  logic [31:0]   wrap_count;

  // command strokes act at the same edge as the write
  logic cmd_load;
  logic cmd_clear;
  logic cmd_match_clr;
  logic cmd_wraps_clr;

  assign cmd_load      = (wr_sel == sdc_pkg::SDC_SEL_CMD) && bus.wdata[`SDC_CMD_LOAD_BIT];
  assign cmd_clear     = (wr_sel == sdc_pkg::SDC_SEL_CMD) && bus.wdata[`SDC_CMD_CLEAR_BIT];
  assign cmd_match_clr = (wr_sel == sdc_pkg::SDC_SEL_CMD) && bus.wdata[`SDC_CMD_MATCH_BIT];
  assign cmd_wraps_clr = (wr_sel == sdc_pkg::SDC_SEL_CMD) && bus.wdata[`SDC_CMD_WRAPS_BIT];

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      sw_cep_gate <= `SDC_CTRL_RESET_CEP;
      sw_cet_gate <= `SDC_CTRL_RESET_CET;
    end else if (wr_sel == sdc_pkg::SDC_SEL_CTRL) begin
      sw_cep_gate <= bus.wdata[`SDC_CTRL_CEP_BIT];
      sw_cet_gate <= bus.wdata[`SDC_CTRL_CET_BIT];
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      sw_preset <= '0;
    end else if (wr_sel == sdc_pkg::SDC_SEL_PRESET) begin
      sw_preset <= bus.wdata[CW-1:0];
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      match_value <= '0;
    end else if (wr_sel == sdc_pkg::SDC_SEL_MATCH) begin
      match_value <= bus.wdata[CW-1:0];
    end
  end

  // controls as every stage sees them
  logic          pin_load;
  logic          any_load;
  logic          any_sync_clear;
  logic          cep_eff;
  logic [CW-1:0] load_value;

  assign pin_load       = !load_n_in;
  assign any_load       = pin_load || cmd_load;
  // the pin wins over software when both load in one edge
  assign load_value     = pin_load ? preset_in : sw_preset;
  assign any_sync_clear = cmd_clear || (!ASYNC_CLEAR && !clear_n_in);
  assign cep_eff        = count_enable_parallel_in && sw_cep_gate;

  logic [NUM_STAGES:0]   trickle_chain;
  logic [NUM_STAGES-1:0] stage_tf;

  // each stage's flag feeds the next stage's trickle enable
  assign trickle_chain[0] = count_enable_trickle_in && sw_cet_gate;

  genvar g;
  generate
    for (g = 0; g < NUM_STAGES; g++) begin : g_stage
      sdc_pkg::sdc_stage_ctrl_type stage_ctrl;

      assign stage_ctrl.sync_clear            = any_sync_clear;
      assign stage_ctrl.load_n                = !any_load;
      assign stage_ctrl.count_enable_parallel = cep_eff;
      assign stage_ctrl.count_enable_trickle  = trickle_chain[g];

      sdc_decade_stage #(
        .ASYNC_CLEAR (ASYNC_CLEAR)
      ) u_stage (
        .clk_sys_in        (clk_sys_in),
        .rst_in            (rst_in),
        .clear_n_in        (clear_n_in),
        .ctrl_in           (stage_ctrl),
        .preset_in         (load_value[4*g +: 4]),
        .count_out         (count_out[4*g +: 4]),
        .terminal_flag_out (stage_tf[g])
      );

      assign trickle_chain[g+1] = stage_tf[g];
    end
  endgenerate

  assign terminal_flag_out = stage_tf[NUM_STAGES-1];

  // the whole chain rolls over from all nines on this edge
  logic wrap_event;
  logic match_event;

  assign wrap_event  = terminal_flag_out && cep_eff && !any_load && !any_sync_clear;
  assign match_event = (count_out == match_value);

  // a clear on a wrap edge restarts the count at one; a match hit beats its clear
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      wrap_count <= '0;
    end else if (cmd_wraps_clr) begin
      wrap_count <= wrap_event ? 32'h0000_0001 : 32'h0000_0000;
    end else if (wrap_event) begin
      wrap_count <= wrap_count + 32'h0000_0001;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      match_hit <= 1'b0;
    end else if (match_event) begin
      match_hit <= 1'b1;
    end else if (cmd_match_clr) begin
      match_hit <= 1'b0;
    end
  end

  // status word: packed digits low, flags high
  logic [31:0] status_word;
  logic [31:0] ctrl_word;
  logic [31:0] preset_word;
  logic [31:0] match_word;

  always_comb begin
    status_word                      = 32'h0000_0000;
    status_word[CW-1:0]              = count_out;
    status_word[`SDC_STAT_TF_BIT]    = terminal_flag_out;
    status_word[`SDC_STAT_MATCH_BIT] = match_hit;
  end

  always_comb begin
    ctrl_word                     = 32'h0000_0000;
    ctrl_word[`SDC_CTRL_CEP_BIT]  = sw_cep_gate;
    ctrl_word[`SDC_CTRL_CET_BIT]  = sw_cet_gate;
  end

  always_comb begin
    preset_word         = 32'h0000_0000;
    preset_word[CW-1:0] = sw_preset;
    match_word          = 32'h0000_0000;
    match_word[CW-1:0]  = match_value;
  end

  logic [31:0] next_rdata;

  always_comb begin
    case (rd_sel)
      sdc_pkg::SDC_SEL_CTRL:   next_rdata = ctrl_word;
      sdc_pkg::SDC_SEL_PRESET: next_rdata = preset_word;
      sdc_pkg::SDC_SEL_STATUS: next_rdata = status_word;
      sdc_pkg::SDC_SEL_WRAPS:  next_rdata = wrap_count;
      sdc_pkg::SDC_SEL_MATCH:  next_rdata = match_word;
      sdc_pkg::SDC_SEL_INFO:   next_rdata = INFO_CODE;
      default:                 next_rdata = 32'h0000_0000;
    endcase
  end

  // data stands one cycle only, zero otherwise; command and unmapped read zero
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      reg_rdata_out <= 32'h0000_0000;
    end else begin
      reg_rdata_out <= next_rdata;
    end
  end

endmodule : sdc_counter_top

`default_nettype wire

// [sim/sdc_counter_monitor.sv]
`timescale 1ns/1ps
`default_nettype none
module sdc_counter_monitor #(
  parameter int NUM_STAGES  = 1,
  parameter bit ASYNC_CLEAR = 1'b1
) (
  // clock, reset and counter pins
  input wire logic                    clk_sys_in,
  input wire logic                    rst_in,
  input wire logic                    clear_n_in,
  input wire logic                    load_n_in,
  input wire logic                    count_enable_parallel_in,
  input wire logic                    count_enable_trickle_in,
  input wire logic [4*NUM_STAGES-1:0] preset_in,
  input wire logic [4*NUM_STAGES-1:0] count_out,
  input wire logic                    terminal_flag_out,
  // register port
  input wire logic [7:0]              reg_addr_in,
  input wire logic [31:0]             reg_wdata_in,
  input wire logic                    reg_wr_in,
  input wire logic                    reg_rd_in,
  input wire logic [31:0]             reg_rdata_out
);
  logic [1:0] gate;
  logic       cmdw;
  logic       run;
  // software gates and commands also steer the count, so track them here
  assign cmdw = reg_wr_in && reg_addr_in == 8'h08 && |reg_wdata_in[1:0];
  assign run  = clear_n_in && load_n_in && !cmdw && count_enable_parallel_in && count_enable_trickle_in && &gate;
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      gate <= 2'h3;
    end else if (reg_wr_in && reg_addr_in == 8'h00) begin
      gate <= reg_wdata_in[1:0];
    end
  end
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (rst_in);
  a_load_copies: assert property (clear_n_in && !load_n_in && !cmdw
                                  |=> !clear_n_in || count_out == $past(preset_in))
    else $error("load did not copy preset");
  a_count_step: assert property (run && count_out < 4'h9 |=> !clear_n_in || count_out == $past(count_out) + 1'b1)
    else $error("count did not step");
  a_wrap_nine: assert property (run && count_out == 4'h9 |=> !clear_n_in || count_out == 4'h0)
    else $error("nine did not wrap");
  a_hold_idle: assert property (clear_n_in && load_n_in && !cmdw && !run |=> !clear_n_in || $stable(count_out))
    else $error("count moved while idle");
  a_clear_zero: assert property (ASYNC_CLEAR && !clear_n_in |-> count_out == '0 && !terminal_flag_out)
    else $error("clear did not zero");
  a_clear_next: assert property (!clear_n_in |=> count_out == '0 && !terminal_flag_out)
    else $error("clear edge did not zero");
  a_flag_cause: assert property (terminal_flag_out |-> count_enable_trickle_in && count_out == 4'h9)
    else $error("flag without cause");
  a_flag_shown: assert property (clear_n_in && count_enable_trickle_in && gate[1] && count_out == 4'h9
                                 |-> terminal_flag_out)
    else $error("flag missing at nine");
  a_read_idle: assert property (!$past(reg_rd_in) |-> reg_rdata_out == 32'h0)
    else $error("read data outside read slot");
  c_wrap: cover property (run && count_out == 4'h9);
  c_clear: cover property (!clear_n_in);
  c_read: cover property ($past(reg_rd_in) && reg_rdata_out != 32'h0);
endmodule : sdc_counter_monitor
bind sdc_counter_top sdc_counter_monitor #(.NUM_STAGES(NUM_STAGES), .ASYNC_CLEAR(ASYNC_CLEAR)) u_sdc_counter_monitor (
  .clk_sys_in, .rst_in, .clear_n_in, .load_n_in, .count_enable_parallel_in, .count_enable_trickle_in,
  .preset_in, .count_out, .terminal_flag_out, .reg_addr_in, .reg_wdata_in, .reg_wr_in, .reg_rd_in,
  .reg_rdata_out);
`default_nettype wire

// [sim/sdc_upper_stage.sv]
`timescale 1ns/1ps
`default_nettype none
module sdc_upper_stage (
  // clock and reset
  input  wire logic       clk_sys_in,
  input  wire logic       rst_in,
  // cascade from the lower digit
  input  wire logic       clear_n_in,
  input  wire logic       load_n_in,
  input  wire logic       count_enable_parallel_in,
  input  wire logic       carry_in,
  output logic      [3:0] digit_out
);
  // a shared load only holds here; the model tracks carries, not presets
  always_ff @(posedge clk_sys_in or negedge clear_n_in) begin
    if (!clear_n_in) begin
      digit_out <= 4'h0;
    end else if (rst_in) begin
      digit_out <= 4'h0;
    end else if (load_n_in && count_enable_parallel_in && carry_in) begin
      digit_out <= (digit_out == 4'h9) ? 4'h0 : digit_out + 4'h1;
    end
  end
endmodule : sdc_upper_stage
`default_nettype wire

// [sim/sdc_counter_test.sv]
`timescale 1ns/1ps
`default_nettype none
module sdc_counter_test;
  typedef struct {int due; bit rd; logic [31:0] val; logic [31:0] mk;} sdc_note_type;
  localparam logic [31:0] INFO = 32'h0000_5A5A; // arbitrary build code
  logic clk_sys_in = 1'b0, rst_in = 1'b1, clear_n_in = 1'b1, load_n_in = 1'b1;
  logic count_enable_parallel_in = 1'b0, count_enable_trickle_in = 1'b0, reg_wr_in = 1'b0, reg_rd_in = 1'b0;
  logic [3:0]  preset_in = 4'h0, count_out, upper, m = 4'h0, swp = 4'h0;
  logic [7:0]  reg_addr_in = 8'h00;
  logic [31:0] reg_wdata_in = 32'h0, reg_rdata_out;
  logic [16:0] lf = 17'h11FD6;
  logic [1:0]  g = 2'h3;
  logic        terminal_flag_out;
  logic [3:0]  count_sync;
  logic        flag_sync;
  int          cyc = 0, mismatches = 0, num_checks = 0, w = 0;
  sdc_note_type q[$];

  always #4 clk_sys_in = ~clk_sys_in;
  always @(posedge clk_sys_in) cyc <= cyc + 1;

  sdc_counter_top #(.NUM_STAGES(1), .ASYNC_CLEAR(1'b1), .INFO_CODE(INFO)) u_sdc_counter_top (
    .clk_sys_in, .rst_in, .clear_n_in, .load_n_in, .count_enable_parallel_in, .count_enable_trickle_in,
    .preset_in, .count_out, .terminal_flag_out, .reg_addr_in, .reg_wdata_in, .reg_wr_in, .reg_rd_in,
    .reg_rdata_out);
  sdc_upper_stage u_sdc_upper_stage (.clk_sys_in, .rst_in, .clear_n_in, .load_n_in, .count_enable_parallel_in,
    .carry_in(terminal_flag_out), .digit_out(upper));
  // same stimulus into the clock-edge clear variant
  sdc_counter_top #(.NUM_STAGES(1), .ASYNC_CLEAR(1'b0), .INFO_CODE(INFO)) u_sdc_counter_top_sync (
    .clk_sys_in, .rst_in, .clear_n_in, .load_n_in, .count_enable_parallel_in, .count_enable_trickle_in,
    .preset_in, .count_out(count_sync), .terminal_flag_out(flag_sync), .reg_addr_in, .reg_wdata_in,
    .reg_wr_in, .reg_rd_in, .reg_rdata_out());

  function automatic logic [16:0] nxt(input logic [16:0] s);
    return {s[15:0], s[16] ^ s[13]};
  endfunction : nxt

  task chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    num_checks++;
    if (s !== e) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", nm, e, s);
    end
  endtask : chk

  task conclude;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : conclude

  always @(negedge clk_sys_in) begin
    while (q.size() > 0 && q[0].due == cyc) begin
      if (q[0].rd) chk("read data", q[0].val & q[0].mk, reg_rdata_out & q[0].mk);
      else chk("count", q[0].val, {28'h0, count_out});
      void'(q.pop_front());
    end
  end

  // c is {load_n, parallel enable, trickle enable}; b is {write, read}
  task go(input logic [2:0] c, input logic [3:0] p = 4'h0, input logic [1:0] b = 2'b00,
          input logic [7:0] a = 8'h00, input logic [31:0] d = 32'h0, input logic [31:0] e = 32'h0,
          input logic [31:0] mk = 32'hFFFF_FFFF);
    @(posedge clk_sys_in);
    {load_n_in, count_enable_parallel_in, count_enable_trickle_in} <= c;
    clear_n_in <= 1'b1;
    preset_in <= p;
    {reg_wr_in, reg_rd_in} <= b;
    reg_addr_in <= a;
    reg_wdata_in <= d;
    if (b[1] && a == 8'h08 && d[1]) m = 4'h0;
    else if (!c[2]) m = p;
    else if (b[1] && a == 8'h08 && d[0]) m = swp;
    else if (&c[1:0] && &g) begin
      w = w + int'(m == 4'h9);
      m = (m == 4'h9) ? 4'h0 : m + 4'h1;
    end
    if (b[1] && a == 8'h00) g = d[1:0];
    if (b[1] && a == 8'h04) swp = d[3:0];
    q.push_back('{cyc + 2, 1'b0, {28'h0, m}, 32'hF});
    if (b[0]) q.push_back('{cyc + 2, 1'b1, e, mk});
  endtask : go

  task clr;
    repeat (2) @(posedge clk_sys_in);
    clear_n_in <= 1'b0;
    #1;
    chk("cleared count", 32'h0, {28'h0, count_out});
    chk("cleared flag", 32'h0, {31'h0, terminal_flag_out});
    chk("sync clear waits", {28'h0, m}, {28'h0, count_sync});
    m = 4'h0;
  endtask : clr

  initial begin
    repeat (2) @(posedge clk_sys_in);
    rst_in <= 1'b0;
    go(3'b100);
    go(3'b000, 4'h8);
    repeat (3) go(3'b111);
    go(3'b101);
    go(3'b110);
    go(3'b011, 4'h3);
    repeat (60) begin
      lf = nxt(lf);
      go({|lf[2:1], lf[3] | lf[4], lf[5] | lf[6]}, lf[10:7]);
    end
    go(3'b000, 4'h0, 2'b01, 8'h18, 32'h0, INFO);
    go(3'b100, 4'h0, 2'b01, 8'h1C);
    go(3'b100, 4'h0, 2'b01, 8'h08);
    go(3'b100, 4'h0, 2'b10, 8'h14, 32'h5);
    go(3'b100, 4'h0, 2'b01, 8'h14, 32'h0, 32'h5);
    go(3'b100, 4'h0, 2'b10, 8'h00, 32'h0);
    repeat (2) go(3'b111);
    go(3'b100, 4'h0, 2'b01, 8'h00, 32'h0, 32'h0);
    go(3'b100, 4'h0, 2'b10, 8'h00, 32'h3);
    go(3'b100, 4'h0, 2'b10, 8'h04, 32'h7);
    go(3'b100, 4'h0, 2'b10, 8'h08, 32'h1);
    go(3'b100, 4'h0, 2'b01, 8'h0C, 32'h0, {28'h0, m}, 32'hF);
    go(3'b100, 4'h0, 2'b01, 8'h10, 32'h0, w);
    go(3'b100, 4'h0, 2'b10, 8'h08, 32'hE);
    go(3'b100, 4'h0, 2'b01, 8'h10);
    go(3'b100, 4'h0, 2'b01, 8'h0C, 32'h0, 32'h0, 32'hC000_000F);
    go(3'b000, 4'h9);
    go(3'b101, 4'h0, 2'b01, 8'h0C, 32'h0, 32'h8000_0009, 32'hC000_000F);
    go(3'b000, 4'h5);
    go(3'b100);
    go(3'b100, 4'h0, 2'b01, 8'h0C, 32'h0, 32'h4000_0005, 32'hC000_000F);
    go(3'b100);
    chk("upper digit", 32'(w % 10), {28'h0, upper});
    clr;
    go(3'b111);
    #1 chk("sync cleared", 32'h0, {27'h0, flag_sync, count_sync});
    go(3'b100);
    repeat (4) @(posedge clk_sys_in);
    conclude;
  end

  initial begin
    #20000;
    mismatches++;
    conclude;
  end
endmodule : sdc_counter_test
`default_nettype wire
